//--- hdl/owbrx_bit_if.sv
// Link between the bit timer and the frame logic.
`timescale 1ns/100ps
interface owbrx_bit_if;
  logic hold;
  logic bit_stb;
  logic bit_val;
  logic bit_bad;
  logic frame_end;
  modport src (input hold, output bit_stb, bit_val, bit_bad, frame_end);
  modport dst (output hold, input bit_stb, bit_val, bit_bad, frame_end);
endinterface

//--- hdl/owbrx_bit_timer.sv
// Measures low and high times of each bit and decodes it by ratio.
`timescale 1ns/100ps
`include "owbrx_cfg.svh"
module owbrx_bit_timer
  import owbrx_pkg::*;
#(
  parameter int CNT_W   = 17,
  parameter int EOS_CYC = `OWBRX_EOS_CYC
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  // Line
  input  wire logic line_in,
  // Decoded bits
  owbrx_bit_if.src  bits
);
  // Refuse a timeout that the phase counters cannot reach.
  if (EOS_CYC < 2 || EOS_CYC >= (2 ** CNT_W)) begin
    $error("owbrx_bit_timer: EOS_CYC does not fit CNT_W");
  end

  localparam logic [CNT_W-1:0] EOS_LIM = CNT_W'(EOS_CYC);

  logic             line_q, line_d;
  logic             run_q, run_d;
  logic [CNT_W-1:0] lo_q, lo_d, hi_q, hi_d;
  logic             stb_q, stb_d, val_q, val_d, bad_q, bad_d, end_q, end_d;
  logic [CNT_W:0]   lo2, hi2;

  assign lo2 = {lo_q, 1'b0};
  assign hi2 = {hi_q, 1'b0};
  assign bits.bit_stb   = stb_q;
  assign bits.bit_val   = val_q;
  assign bits.bit_bad   = bad_q;
  assign bits.frame_end = end_q;

  always_comb begin
    line_d = line_in;
    run_d  = run_q;
    lo_d   = lo_q;
    hi_d   = hi_q;
    stb_d  = 1'b0;
    val_d  = val_q;
    bad_d  = 1'b0;
    end_d  = 1'b0;
    if (bits.hold) begin
      run_d = 1'b0;
      lo_d  = '0;
      hi_d  = '0;
    end else if (line_q && !line_in) begin
      // A falling edge closes the running bit and opens the next. RQ13
      if (run_q) begin
        stb_d = 1'b1;
        val_d = ({1'b0, hi_q} >= lo2); // RQ13
        bad_d = ({1'b0, hi_q} < lo2) && ({1'b0, lo_q} < hi2); // RQ13
      end
      run_d = 1'b1;
      lo_d  = '0;
      hi_d  = '0;
    end else if (run_q) begin
      // Both phases are timed with no preset rate. RQ12 RQ18
      if (line_in) begin
        hi_d = hi_q + 1'b1;
      end else begin
        lo_d = lo_q + 1'b1;
      end
      // A level held past the longest bit phase ends the frame.
      if (hi_q == EOS_LIM || lo_q == EOS_LIM) begin
        end_d = 1'b1;
        run_d = 1'b0;
        lo_d  = '0;
        hi_d  = '0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      line_q <= 1'b1;
      run_q  <= 1'b0;
      lo_q   <= '0;
      hi_q   <= '0;
      stb_q  <= 1'b0;
      val_q  <= 1'b0;
      bad_q  <= 1'b0;
      end_q  <= 1'b0;
    end else if (ce) begin
      line_q <= line_d;
      run_q  <= run_d;
      lo_q   <= lo_d;
      hi_q   <= hi_d;
      stb_q  <= stb_d;
      val_q  <= val_d;
      bad_q  <= bad_d;
      end_q  <= end_d;
    end
  end
endmodule

//--- hdl/owbrx_cfg.svh
// Constants for the single-wire brightness command receiver.
`ifndef OWBRX_CFG_SVH
`define OWBRX_CFG_SVH
`define OWBRX_ADDR_CTRL   12'h000
`define OWBRX_ADDR_STAT   12'h004
`define OWBRX_DEV_ADDR    8'h8F
`define OWBRX_FRAME_BITS  5'h18
`define OWBRX_CNT_OVF     5'h19
`define OWBRX_CODE_RST    9'h1FF
`define OWBRX_ADDR_MSB    23
`define OWBRX_ADDR_LSB    16
`define OWBRX_RFA_POS     10
`define OWBRX_CODE_MSB    8
`define OWBRX_CODE_LSB    0
`define OWBRX_CTRL_EN     0
`define OWBRX_CTRL_ACKEN  1
`define OWBRX_CTRL_RST    2'h3
`define OWBRX_STAT_OK     16
`define OWBRX_STAT_REJ    17
`define OWBRX_STAT_ACK    18
`define OWBRX_CLK_NS      8
`define OWBRX_T_EOS_US    400
`define OWBRX_T_ACK_PULLDOWN_US   512
`define OWBRX_EOS_CYC \
  ((`OWBRX_T_EOS_US * 1000 + `OWBRX_CLK_NS - 1) / `OWBRX_CLK_NS)
`define OWBRX_ACK_PULLDOWN_CYC ((`OWBRX_T_ACK_PULLDOWN_US * 1000) / `OWBRX_CLK_NS)
`endif

//--- hdl/owbrx_pkg.sv
// Types shared by the single-wire brightness command receiver.
package owbrx_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ACK
  } owbrx_state_t;
  typedef logic [8:0] owbrx_code_t;
endpackage

//--- hdl/owbrx_top.sv
// Single-wire brightness command receiver with APB control.
//
// Functional notes
// RQ1 - Frame must be exactly 24 bits.
// RQ2 - Address bits 23..16, data bits 15..0.
// RQ3 - Master sends whole frame in one go.
// RQ4 - LSB first; last bit lands in 23.
// RQ5 - Only address 0x8F is accepted.
// RQ6 - Bits 8..0 load the brightness code.
// RQ7 - Master writes zero to unused bits.
// RQ8 - Bit 10 requests an acknowledge.
// RQ9 - Acknowledge only for good, requested frames.
// RQ10 - Acknowledge pulls the line low.
// RQ11 - Acknowledge request needs open-drain master.
// RQ12 - Decode any rate 1.7 to 160 kbit/s.
// RQ13 - Bit value from low/high time ratio.
// RQ14 - Master gives start and end-of-stream highs; the master model and timer use an end-of-stream low.
// RQ15 - Acknowledge low lasts at most 512 us.
// RQ16 - Code is all ones at enable/disable.
// RQ17 - Foreign address frames are dropped silently.
// RQ18 - Bit phases timed by system clock counters.
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/100ps
`include "owbrx_cfg.svh"
module owbrx_top
  import owbrx_pkg::*;
#(
  parameter int CNT_W   = 17,
  parameter int EOS_CYC = `OWBRX_EOS_CYC,
  parameter int ACK_CYC = `OWBRX_ACK_PULLDOWN_CYC
) (
  // Clock, reset, clock enable
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Command line, open drain
  input  wire logic        line_in,
  output logic             line_out,
  output logic             line_oe,
  // Brightness code to the current sinks
  output logic [8:0]       brightness_code
);
  // Refuse an acknowledge length that the counter cannot reach.
  if (ACK_CYC < 1 || ACK_CYC >= (2 ** CNT_W)) begin
    $error("owbrx_top: ACK_CYC does not fit CNT_W");
  end

  localparam logic [CNT_W-1:0] ACK_LIM = CNT_W'(ACK_CYC - 1);

  owbrx_bit_if bits ();

  owbrx_bit_timer #(
    .CNT_W   (CNT_W),
    .EOS_CYC (EOS_CYC)
  ) u_timer (
    .clk     (clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .line_in (line_in),
    .bits    (bits.src)
  );

  // APB registers.
  logic [1:0]  ctrl_q, ctrl_d;
  logic [31:0] prdata_q, prdata_d;
  logic        pready_q, pready_d, pslverr_q, pslverr_d;
  // Frame and acknowledge state.
  logic [23:0]      sh_q, sh_d;
  logic [4:0]       cnt_q, cnt_d;
  logic             bad_q, bad_d, ok_q, ok_d, rej_q, rej_d;
  owbrx_code_t      code_q, code_d;
  owbrx_state_t     st_q, st_d;
  logic [CNT_W-1:0] ack_q, ack_d;
  logic             oe_q, oe_d;
  logic             good;

  assign prdata          = prdata_q;
  assign pready          = pready_q;
  assign pslverr         = pslverr_q;
  assign line_out        = 1'b0;
  assign line_oe         = oe_q;
  assign brightness_code = code_q;
  // The timer is parked while disabled and while this end drives the line,
  // so the acknowledge low is never mistaken for a bit.
  assign bits.hold = !ctrl_q[`OWBRX_CTRL_EN] || (st_q == ST_ACK);

  // One wait state: pready rises in the second access cycle.
  always_comb begin
    ctrl_d    = ctrl_q;
    prdata_d  = prdata_q;
    pready_d  = 1'b0;
    pslverr_d = 1'b0;
    if (psel && penable && !pready_q) begin
      pready_d = 1'b1;
      prdata_d = '0;
      case (paddr)
        `OWBRX_ADDR_CTRL: begin
          if (!pwrite) begin
            prdata_d[1:0] = ctrl_q;
          end
        end
        `OWBRX_ADDR_STAT: begin
          if (!pwrite) begin
            prdata_d[`OWBRX_CODE_MSB:`OWBRX_CODE_LSB] = code_q;
            prdata_d[`OWBRX_STAT_OK]  = ok_q;
            prdata_d[`OWBRX_STAT_REJ] = rej_q;
            prdata_d[`OWBRX_STAT_ACK] = (st_q == ST_ACK);
          end
        end
        default: begin
          pslverr_d = 1'b1;
        end
      endcase
    end
    // The write lands only at the edge that completes the transfer, so a
    // master that stalls in the access phase never sees an early effect.
    if (psel && penable && pready_q && pwrite &&
        (paddr == `OWBRX_ADDR_CTRL)) begin
      ctrl_d = pwdata[1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_q    <= `OWBRX_CTRL_RST;
      prdata_q  <= '0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else if (ce) begin
      ctrl_q    <= ctrl_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // Accepted: full count, no ambiguous bit, own address. RQ1 RQ5 RQ9
  assign good = (cnt_q == `OWBRX_FRAME_BITS) && !bad_q &&
                (sh_q[`OWBRX_ADDR_MSB:`OWBRX_ADDR_LSB] == `OWBRX_DEV_ADDR);

  always_comb begin
    sh_d   = sh_q;
    cnt_d  = cnt_q;
    bad_d  = bad_q;
    ok_d   = ok_q;
    rej_d  = rej_q;
    code_d = code_q;
    st_d   = st_q;
    ack_d  = ack_q;
    oe_d   = 1'b0;
    if (!ctrl_q[`OWBRX_CTRL_EN]) begin
      // Disabled means shut down: drop any frame and restore the code. RQ16
      code_d = `OWBRX_CODE_RST;
      cnt_d  = '0;
      bad_d  = 1'b0;
      st_d   = ST_IDLE;
      ack_d  = '0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (bits.bit_stb) begin
            sh_d = {bits.bit_val, sh_q[23:1]}; // RQ4 RQ2
            if (cnt_q != `OWBRX_CNT_OVF) begin
              cnt_d = cnt_q + 5'h01; // RQ1
            end
            bad_d = bad_q || bits.bit_bad;
          end
          if (bits.frame_end) begin
            cnt_d = '0;
            bad_d = 1'b0;
            ok_d  = good;
            rej_d = !good; // RQ17
            if (good) begin
              code_d = sh_q[`OWBRX_CODE_MSB:`OWBRX_CODE_LSB]; // RQ6
              // Frame end comes one timeout after the last falling edge,
              // which serves as the acknowledge valid delay. RQ15
              if (sh_q[`OWBRX_RFA_POS] && ctrl_q[`OWBRX_CTRL_ACKEN]) begin
                st_d  = ST_ACK; // RQ8 RQ9
                ack_d = '0;
                oe_d  = 1'b1;
              end
            end
          end
        end
        ST_ACK: begin
          oe_d  = 1'b1; // RQ10
          ack_d = ack_q + 1'b1;
          if (ack_q == ACK_LIM) begin
            oe_d = 1'b0; // RQ15
            st_d = ST_IDLE;
          end
        end
        default: begin
          st_d = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sh_q   <= '0;
      cnt_q  <= '0;
      bad_q  <= 1'b0;
      ok_q   <= 1'b0;
      rej_q  <= 1'b0;
      code_q <= `OWBRX_CODE_RST; // RQ16
      st_q   <= ST_IDLE;
      ack_q  <= '0;
      oe_q   <= 1'b0;
    end else if (ce) begin
      sh_q   <= sh_d;
      cnt_q  <= cnt_d;
      bad_q  <= bad_d;
      ok_q   <= ok_d;
      rej_q  <= rej_d;
      code_q <= code_d;
      st_q   <= st_d;
      ack_q  <= ack_d;
      oe_q   <= oe_d;
    end
  end
endmodule

//--- verification/owbrx_chk.sv
// Port-level timing checker for the brightness command receiver.
`timescale 1ns/100ps
module owbrx_chk #(
  parameter int ACK_CYC = 100
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        ce,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  // Line and code
  input wire logic        line_in,
  input wire logic        line_out,
  input wire logic        line_oe,
  input wire logic [8:0]  brightness_code
);
  logic [16:0] hi_q;
  logic [16:0] hi_d;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Counts the cycles of one acknowledge pulse.
  always_comb hi_d = line_oe ? hi_q + 17'h00001 : 17'h00000;
  always_ff @(posedge clk) begin
    hi_q <= rst_n ? hi_d : 17'h00000;
  end
  a_ready_one_wait: assert property (ce && psel && penable && !pready
    |=> pready)
    else $error("no answer one cycle after access");
  a_no_early_ready: assert property (psel && !penable |=> !pready)
    else $error("answer during setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_zero_data: assert property (pslverr |-> pready && prdata == 0)
    else $error("error without ready or with data");
  a_line_out_low: assert property (line_out == 1'b0)
    else $error("line drive value not low");
  a_ack_full_len: assert property ($fell(line_oe) |-> hi_q == ACK_CYC)
    else $error("acknowledge length wrong");
  a_ack_not_long: assert property (line_oe |-> hi_q < ACK_CYC)
    else $error("acknowledge too long");
  a_code_hold_ack: assert property (line_oe |=> $stable(brightness_code))
    else $error("code moved during acknowledge");
  a_code_after_idle: assert property ($changed(brightness_code) &&
    brightness_code != 9'h1FF |-> $past(line_in, 2) == $past(line_in, 6))
    else $error("code loaded while line active");
endmodule

bind owbrx_top owbrx_chk #(.ACK_CYC(ACK_CYC)) owbrx_chk_i (
  .clk(clk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .line_in(line_in), .line_out(line_out), .line_oe(line_oe),
  .brightness_code(brightness_code));

//--- verification/owbrx_master.sv
// Master model that sends commands on the open-drain line.
`timescale 1ns/100ps
module owbrx_master #(
  parameter int EOS_CYC = 200,
  parameter int ACK_CYC = 100
) (
  // Clock
  input wire logic clk,
  // Line, pulled up
  input wire logic line,
  output logic     mst_low
);
  initial mst_low = 1'b0;
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Short phase t, long phase 3t; n below 24 gives a truncated frame.
  task automatic send(input logic [23:0] f, input int n, input int t,
                      output logic ack);
    hold(3 * t);
    for (int i = 0; i < n; i++) begin
      mst_low <= 1'b1;
      hold(f[i] ? t : 3 * t);
      mst_low <= 1'b0;
      hold(f[i] ? 3 * t : t);
    end
    mst_low <= 1'b1;
    hold(EOS_CYC + 4);
    mst_low <= 1'b0;
    hold(3);
    ack = !line;
    hold(ACK_CYC + 3 * t);
  endtask
endmodule

//--- verification/owbrx_top_bench.sv
// Testbench of the brightness command receiver.
`timescale 1ns/100ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; \
  $display("mismatch %0t got %h exp %h", $time, (a), (b)); end end
module owbrx_top_bench;
  localparam int EOS = 600;
  localparam int ACK = 100;
  logic        clk, rst_n, ce, psel, penable, pwrite, err, ack;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, line_out, line_oe, mst_low, line_in;
  logic [8:0]  brightness_code;
  int          errors = 0;
  int          n_compared = 0;
  int          cyc = 0;
  // Open-drain wire with pull-up: low if either side pulls.
  assign line_in = !(mst_low || line_oe);
  owbrx_top #(.EOS_CYC(EOS), .ACK_CYC(ACK)) owbrx_top_i (
    .clk(clk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .line_in(line_in),
    .line_out(line_out), .line_oe(line_oe),
    .brightness_code(brightness_code));
  owbrx_master #(.EOS_CYC(EOS), .ACK_CYC(ACK)) owbrx_master_i (
    .clk(clk), .line(line_in), .mst_low(mst_low));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      errors++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  function automatic logic [23:0] fr(input logic [8:0] c, input logic r,
                                     input logic [7:0] a);
    return {a, 5'h00, r, 1'b0, c};
  endfunction
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    `CHK(brightness_code, 9'h1FF)
    apb(1'b0, 12'h000, 32'h0);
    `CHK(rd, 32'h00000003)
    apb(1'b1, 12'h008, 32'h1);
    `CHK(err, 1'b1)
    apb(1'b1, 12'h004, 32'h0);
    `CHK(err, 1'b0)
    // A low clock enable must stall the transfer until it returns.
    ce <= 1'b0;
    fork
      apb(1'b0, 12'h000, 32'h0);
      begin
        repeat (6) @(posedge clk);
        `CHK(pready, 1'b0)
        ce <= 1'b1;
      end
    join
    `CHK(rd, 32'h00000003)
    owbrx_master_i.send(fr(9'h0A5, 1'b0, 8'h8F), 24, 5, ack);
    `CHK(ack, 1'b0)
    `CHK(brightness_code, 9'h0A5)
    apb(1'b0, 12'h004, 32'h0);
    `CHK(rd[17:0], 18'h100A5)
    // Bits at about 160 kbit/s; long phases sit just below the timeout.
    owbrx_master_i.send(fr(9'h13C, 1'b1, 8'h8F), 24, 196, ack);
    `CHK(ack, 1'b1)
    `CHK(brightness_code, 9'h13C)
    owbrx_master_i.send(fr(9'h055, 1'b1, 8'h8E), 24, 5, ack);
    `CHK(ack, 1'b0)
    `CHK(brightness_code, 9'h13C)
    apb(1'b0, 12'h004, 32'h0);
    `CHK(rd[17:16], 2'h2)
    owbrx_master_i.send(fr(9'h055, 1'b1, 8'h8F), 23, 5, ack);
    `CHK(ack, 1'b0)
    `CHK(brightness_code, 9'h13C)
    apb(1'b1, 12'h000, 32'h1);
    owbrx_master_i.send(fr(9'h0F0, 1'b1, 8'h8F), 24, 5, ack);
    `CHK(ack, 1'b0)
    `CHK(brightness_code, 9'h0F0)
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b0, 12'h004, 32'h0);
    `CHK(rd[8:0], 9'h1FF)
    `CHK(brightness_code, 9'h1FF)
    apb(1'b1, 12'h000, 32'h3);
    // Status must show the acknowledge while the line is held low.
    fork
      owbrx_master_i.send(fr(9'h000, 1'b1, 8'h8F), 24, 5, ack);
      begin
        wait (line_oe === 1'b1);
        @(posedge clk);
        apb(1'b0, 12'h004, 32'h0);
        `CHK(rd[18], 1'b1)
        `CHK(rd[8:0], 9'h000)
      end
    join
    `CHK(ack, 1'b1)
    `CHK(brightness_code, 9'h000)
    give_verdict();
  end
endmodule
